// file: core/sfd_consts.svh
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

// Core clock period and strap settling time, both in nanoseconds.
`define SFD_CLK_PERIOD     10
`define SFD_FILT_TIME      200
`define SFD_FILT_CYC       ((`SFD_FILT_TIME + `SFD_CLK_PERIOD - 1) / `SFD_CLK_PERIOD)

// Power-up calibration delays, counted in sample clock cycles.
`define SFD_CAL_SHORT_CYC  256
`define SFD_CAL_LONG_CYC   65536

// Strap pin positions in the comparator input vector.
`define SFD_PIN_RANGE      0
`define SFD_PIN_RMODE      1
`define SFD_PIN_PRIMARY    2
`define SFD_PIN_DELAY      3
`define SFD_PIN_SYNC_POS   4
`define SFD_PIN_SAMPLE_CLK 5
`define SFD_PIN_CNT        6
`define SFD_TRI_CNT        4

// Register byte offsets.
`define SFD_REG_CTRL       12'h000
`define SFD_REG_STATUS     12'h004
`define SFD_REG_PINS       12'h008

// Control register fields and reset value.
`define SFD_CTRL_RANGE_BIT 0
`define SFD_CTRL_RECAL_BIT 1
`define SFD_CTRL_RST       1'b1

// Status register fields.
`define SFD_ST_EXT_BIT     0
`define SFD_ST_ALT_BIT     1
`define SFD_ST_DIFF_BIT    2
`define SFD_ST_RANGE_BIT   3
`define SFD_ST_DES_BIT     4
`define SFD_ST_LONG_BIT    5
`define SFD_ST_BUSY_BIT    6
`define SFD_ST_VALID_BIT   7

// Bus responses.
`define SFD_RESP_OKAY      2'b00
`define SFD_RESP_SLVERR    2'b10

`endif

// file: core/sfd_pkg.sv
package sfd_pkg;

    // Resolved level of a three-state strap pin.
    typedef enum logic [1:0] {
        SFD_LVL_LOW,
        SFD_LVL_HIGH,
        SFD_LVL_MID
    } sfd_lvl_e;

    // Window comparator pair of one pin: above the upper and below the lower threshold.
    typedef struct packed {
        logic above;
        logic below;
    } sfd_cmp_s;

    // Decoded operating selections.
    typedef struct packed {
        logic ext;
        logic alt;
        logic diff;
        logic range_high;
        logic des;
        logic cal_long;
        logic cs_n;
    } sfd_mode_s;

endpackage

// file: core/sfd_strap_resolve.sv
`timescale 1ns/1ps
`include "sfd_consts.svh"

module sfd_strap_resolve #(
    parameter int N    = `SFD_PIN_CNT,
    parameter int FILT = `SFD_FILT_CYC,
    parameter int CW   = 8
) (
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    // Comparator pairs from the pads.
    input  wire sfd_pkg::sfd_cmp_s [N-1:0]   pin_cmp,
    // Filtered levels and synchronised raw high levels.
    output sfd_pkg::sfd_lvl_e      [N-1:0]   lvl,
    output logic                   [N-1:0]   now_high,
    output logic                   [N-1:0]   valid
);

    localparam logic [CW-1:0] LIM = CW'(FILT - 1);

    typedef struct packed {
        sfd_pkg::sfd_cmp_s [N-1:0] s1;
        sfd_pkg::sfd_cmp_s [N-1:0] s2;
        sfd_pkg::sfd_lvl_e [N-1:0] cand;
        sfd_pkg::sfd_lvl_e [N-1:0] lvl;
        logic [N-1:0][CW-1:0]      cnt;
        logic [N-1:0]              ok;
    } sfd_rsv_st_s;

    sfd_rsv_st_s q;
    sfd_rsv_st_s d;
    sfd_pkg::sfd_lvl_e [N-1:0] raw_w;
    sfd_pkg::sfd_lvl_e [N-1:0] lvl_w;
    logic [N-1:0][CW-1:0]      cnt_w;
    logic [N-1:0]              ok_w;

    // A level is accepted only after it has stood unchanged for FILT cycles,
    // so a slowly settling mid-supply strap never shows a false high or low.
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic hit;
        assign raw_w[i] = (q.s2[i].above && !q.s2[i].below) ? sfd_pkg::SFD_LVL_HIGH :
                          (!q.s2[i].above && q.s2[i].below) ? sfd_pkg::SFD_LVL_LOW :
                                                              sfd_pkg::SFD_LVL_MID;
        assign hit      = (raw_w[i] == q.cand[i]) && (q.cnt[i] == LIM);
        assign cnt_w[i] = (raw_w[i] != q.cand[i]) ? '0 :
                          (q.cnt[i] == LIM) ? q.cnt[i] : q.cnt[i] + 1'b1;
        assign lvl_w[i] = hit ? q.cand[i] : q.lvl[i];
        assign ok_w[i]  = q.ok[i] | hit;
    end

    // Next state: two synchroniser stages, then the settling filter.
    always_comb begin
        d      = q;
        d.s1   = pin_cmp;
        d.s2   = q.s1;
        d.cand = raw_w;
        d.cnt  = cnt_w;
        d.lvl  = lvl_w;
        d.ok   = ok_w;
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register.
    assign lvl   = q.lvl;
    assign valid = q.ok;
    for (genvar j = 0; j < N; j++) begin : g_out
        assign now_high[j] = q.s2[j].above;
    end

endmodule

// file: core/sfd_cal_delay.sv
`timescale 1ns/1ps
`include "sfd_consts.svh"

module sfd_cal_delay #(
    parameter int SHORT = `SFD_CAL_SHORT_CYC,
    parameter int LONG  = `SFD_CAL_LONG_CYC,
    parameter int CW    = 24
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Control.
    input  wire logic start,
    input  wire logic long_sel,
    input  wire logic tick,
    // Result.
    output logic      cal_start,
    output logic      busy
);

    localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT - 1);
    localparam logic [CW-1:0] LONG_LAST  = CW'(LONG - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          long_q;
        logic          busy;
        logic          fire;
    } sfd_cal_st_s;

    sfd_cal_st_s q;
    sfd_cal_st_s d;
    logic [CW-1:0] last;

    assign last = q.long_q ? LONG_LAST : SHORT_LAST;

    // Count sample clock ticks; the delay length is latched at start so a strap
    // change mid-count cannot stretch or cut the wait.
    always_comb begin
        d      = q;
        d.fire = 1'b0;
        if (start) begin
            d.busy   = 1'b1;
            d.cnt    = '0;
            d.long_q = long_sel;
        end else if (q.busy && tick) begin
            if (q.cnt == last) begin
                d.busy = 1'b0;
                d.fire = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cal_start = q.fire;
    assign busy      = q.busy;

endmodule

// file: core/sfd_strap_decode.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sfd_consts.svh"

// Overview of operation
// - Range pin acts as range or alternate enable only if reset-mode not low, primary floating.
// - As range select, a low level chooses the reduced full-scale range.
// - As range select, a high level chooses the higher full-scale range.
// - A floating range pin enables extended control mode; host leaves it floating.
// - The primary enable pin overrides the enable taken from the range pin.
// - With reset-mode pin low, the range pin is the negative sync leg.
// - In differential sync mode the full-scale range is forced to the higher level.
// - Outside extended mode, delay pin high or low picks the power-up calibration delay.
// - Floating delay pin selects dual-edge sampling; I doubled, Q ignored.
// - In extended mode the delay pin is the serial chip select.
// - In extended mode the calibration delay setting is forced to zero.
// - Samples are taken on the falling edge of the positive clock leg.
// - Primary enable low activates extended mode; high leaves pin-only control.
// - Reset-mode pin low selects differential sync; high or floating selects single-ended.
module sfd_strap_decode #(
    parameter int CAL_SHORT_CYC = `SFD_CAL_SHORT_CYC,
    parameter int CAL_LONG_CYC  = `SFD_CAL_LONG_CYC
) (
    // Clock and reset.
    input  wire logic                                  core_clk,
    input  wire logic                                  sys_rst,
    // Strap pad comparators.
    input  wire sfd_pkg::sfd_cmp_s [`SFD_PIN_CNT-1:0]  strap_cmp,
    // AXI4-Lite write address channel.
    input  wire logic [11:0]                           s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [11:0]                           s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]                                s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready,
    // Decoded selections.
    output logic                                       full_scale_range_select,
    output logic                                       alternate_extended_control_enable,
    output logic                                       ext_control_active,
    output logic                                       differential_sync_mode,
    output logic                                       calibration_delay_select,
    output logic                                       dual_edge_sampling,
    output logic                                       serial_chip_select_n,
    output logic                                       straps_valid,
    // Output clock sync legs.
    output logic                                       output_clock_sync_neg,
    output logic                                       output_clock_sync,
    // Sampling and calibration.
    output logic                                       sample_strobe,
    output logic                                       calibration_start,
    output logic                                       calibration_busy
);

    typedef struct packed {
        logic               aw_got;
        logic [11:0]        aw_addr;
        logic               w_got;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               range_ext;
        logic               recal;
        logic               clk_prev;
        logic               sample;
        logic               ok_d1;
        logic               ok_d2;
        logic               sync_neg;
        logic               sync_out;
        sfd_pkg::sfd_mode_s mode;
    } sfd_top_st_s;

    sfd_top_st_s q;
    sfd_top_st_s d;

    sfd_pkg::sfd_lvl_e [`SFD_PIN_CNT-1:0] lvl;
    logic [`SFD_PIN_CNT-1:0]              now_high;
    logic [`SFD_PIN_CNT-1:0]              pin_ok;
    logic                                 all_ok;
    logic                                 cal_go;
    logic                                 cal_fire;
    logic                                 cal_busy;
    sfd_pkg::sfd_lvl_e                    l_range;
    sfd_pkg::sfd_lvl_e                    l_rmode;
    sfd_pkg::sfd_lvl_e                    l_pri;
    sfd_pkg::sfd_lvl_e                    l_dly;
    sfd_pkg::sfd_mode_s                   mode_w;
    logic [31:0]                          status_word;
    logic [31:0]                          pins_word;
    logic [31:0]                          ctrl_word;

    // Synchronise and settle every strap pad.
    sfd_strap_resolve #(
        .N    (`SFD_PIN_CNT),
        .FILT (`SFD_FILT_CYC),
        .CW   (8)
    ) u_resolve (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_cmp  (strap_cmp),
        .lvl      (lvl),
        .now_high (now_high),
        .valid    (pin_ok)
    );

    // Power-up calibration delay, restarted when straps first settle or on request.
    sfd_cal_delay #(
        .SHORT (CAL_SHORT_CYC),
        .LONG  (CAL_LONG_CYC),
        .CW    (24)
    ) u_cal (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .start     (cal_go),
        .long_sel  (q.mode.cal_long),
        .tick      (q.sample),
        .cal_start (cal_fire),
        .busy      (cal_busy)
    );

    assign l_range = lvl[`SFD_PIN_RANGE];
    assign l_rmode = lvl[`SFD_PIN_RMODE];
    assign l_pri   = lvl[`SFD_PIN_PRIMARY];
    assign l_dly   = lvl[`SFD_PIN_DELAY];
    assign all_ok  = &pin_ok[`SFD_TRI_CNT-1:0];
    assign cal_go  = (q.ok_d1 && !q.ok_d2) || q.recal;

    // Mode decode from the settled strap levels.
    always_comb begin
        mode_w      = '0;
        mode_w.diff = (l_rmode == sfd_pkg::SFD_LVL_LOW);
        mode_w.alt  = !mode_w.diff && (l_pri == sfd_pkg::SFD_LVL_MID) &&
                      (l_range == sfd_pkg::SFD_LVL_MID);
        case (l_pri)
            sfd_pkg::SFD_LVL_LOW:  mode_w.ext = 1'b1;
            sfd_pkg::SFD_LVL_HIGH: mode_w.ext = 1'b0;
            default:               mode_w.ext = mode_w.alt;
        endcase
        // Range: forced high in differential sync, from software when extended,
        // from the pin only when that pin is free to act as range select.
        if (mode_w.diff) begin
            mode_w.range_high = 1'b1;
        end else if (mode_w.ext) begin
            mode_w.range_high = q.range_ext;
        end else if (l_pri == sfd_pkg::SFD_LVL_MID) begin
            mode_w.range_high = (l_range == sfd_pkg::SFD_LVL_HIGH);
        end else begin
            mode_w.range_high = 1'b1;
        end
        mode_w.des      = !mode_w.ext && (l_dly == sfd_pkg::SFD_LVL_MID);
        mode_w.cal_long = !mode_w.ext && (l_dly == sfd_pkg::SFD_LVL_HIGH);
        mode_w.cs_n     = !(mode_w.ext && (l_dly == sfd_pkg::SFD_LVL_LOW));
    end

    // Read-back words.
    assign ctrl_word   = {31'h0000_0000, q.range_ext};
    assign status_word = {24'h00_0000, all_ok, cal_busy, q.mode.cal_long, q.mode.des,
                          q.mode.range_high, q.mode.diff, q.mode.alt, q.mode.ext};
    assign pins_word   = {24'h00_0000, l_dly, l_pri, l_rmode, l_range};

    // Next state: bus slave, sampling edge, sync legs and registered selections.
    always_comb begin
        d        = q;
        d.recal  = 1'b0;
        d.ok_d1  = all_ok;
        d.ok_d2  = q.ok_d1;
        if (all_ok) begin
            d.mode = mode_w;
        end

        // The sample clock pad is already synchronised; its falling edge
        // marks the instant the input is taken.
        d.clk_prev = now_high[`SFD_PIN_SAMPLE_CLK];
        d.sample   = q.clk_prev && !now_high[`SFD_PIN_SAMPLE_CLK];

        // Sync pulse: in differential mode both legs must agree, which rejects
        // common-mode glitches that a single-ended receiver would pass.
        if (d.mode.diff) begin // Next mode, so the legs switch with the mode output.
            d.sync_neg = now_high[`SFD_PIN_RANGE];
            d.sync_out = now_high[`SFD_PIN_SYNC_POS] && !now_high[`SFD_PIN_RANGE];
        end else begin
            d.sync_neg = 1'b0;
            d.sync_out = now_high[`SFD_PIN_SYNC_POS];
        end

        // Write address and data are taken independently.
        if (s_axi_awvalid && q.awready) begin
            d.aw_got  = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got  = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // Commit once both halves are held and no response is pending.
        if (d.aw_got && d.w_got && !d.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `SFD_RESP_OKAY;
            case ({d.aw_addr[11:2], 2'b00})
                `SFD_REG_CTRL: begin
                    if (d.w_strb[0]) begin
                        d.range_ext = d.w_data[`SFD_CTRL_RANGE_BIT];
                        d.recal     = d.w_data[`SFD_CTRL_RECAL_BIT];
                    end
                end
                `SFD_REG_STATUS, `SFD_REG_PINS: begin
                    d.bresp = `SFD_RESP_OKAY;
                end
                default: begin
                    d.bresp = `SFD_RESP_SLVERR;
                end
            endcase
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready  = !d.w_got && !d.bvalid;

        // Read channel: one outstanding read.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `SFD_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                `SFD_REG_CTRL:   d.rdata = ctrl_word;
                `SFD_REG_STATUS: d.rdata = status_word;
                `SFD_REG_PINS:   d.rdata = pins_word;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `SFD_RESP_SLVERR;
                end
            endcase
        end
        d.arready = !d.rvalid;
    end

    // State register; selections reset to pin-only control at the higher range.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q               <= '0;
            q.awready       <= 1'b1;
            q.wready        <= 1'b1;
            q.arready       <= 1'b1;
            q.range_ext     <= `SFD_CTRL_RST;
            q.mode.range_high <= 1'b1;
            q.mode.cs_n     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops.
    assign s_axi_awready                     = q.awready;
    assign s_axi_wready                      = q.wready;
    assign s_axi_bvalid                      = q.bvalid;
    assign s_axi_bresp                       = q.bresp;
    assign s_axi_arready                     = q.arready;
    assign s_axi_rvalid                      = q.rvalid;
    assign s_axi_rdata                       = q.rdata;
    assign s_axi_rresp                       = q.rresp;
    assign full_scale_range_select           = q.mode.range_high;
    assign alternate_extended_control_enable = q.mode.alt;
    assign ext_control_active                = q.mode.ext;
    assign differential_sync_mode            = q.mode.diff;
    assign calibration_delay_select          = q.mode.cal_long;
    assign dual_edge_sampling                = q.mode.des;
    assign serial_chip_select_n              = q.mode.cs_n;
    assign straps_valid                      = q.ok_d1;
    assign output_clock_sync_neg             = q.sync_neg;
    assign output_clock_sync                 = q.sync_out;
    assign sample_strobe                     = q.sample;
    assign calibration_start                 = cal_fire;
    assign calibration_busy                  = cal_busy;

endmodule

// file: testbench/sfd_strap_decode_asserts.sv
`timescale 1ns/1ps
module sfd_chk (
    // Clock, reset and the sample clock pad.
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_pad,
    // Decoded selections and timing outputs.
    input wire logic full_scale_range_select,
    input wire logic alternate_extended_control_enable,
    input wire logic ext_control_active,
    input wire logic differential_sync_mode,
    input wire logic calibration_delay_select,
    input wire logic dual_edge_sampling,
    input wire logic serial_chip_select_n,
    input wire logic output_clock_sync_neg,
    input wire logic sample_strobe,
    input wire logic calibration_start,
    input wire logic calibration_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Two sync stages and a register put one strobe three edges after a fall.
    sequence s_one_strobe;
        ##3 sample_strobe ##1 !sample_strobe;
    endsequence

    strobe_edge_a: assert property ($fell(clk_pad) |-> s_one_strobe)
        else $error("no strobe after clock fall");
    strobe_rise_a: assert property ($rose(clk_pad) |-> ##3 !sample_strobe)
        else $error("strobe on clock rise");
    fsr_diff_a: assert property (differential_sync_mode |-> full_scale_range_select)
        else $error("reduced range in differential mode");
    ext_cal_a: assert property (ext_control_active |-> !calibration_delay_select)
        else $error("long delay in extended mode");
    des_ext_a: assert property (dual_edge_sampling |-> !ext_control_active)
        else $error("dual edge in extended mode");
    cs_ext_a: assert property (!serial_chip_select_n |-> ext_control_active)
        else $error("chip select outside extended mode");
    alt_ext_a: assert property (alternate_extended_control_enable |->
                                ext_control_active && !differential_sync_mode)
        else $error("alternate enable without extended mode");
    neg_leg_a: assert property (!differential_sync_mode |-> !output_clock_sync_neg)
        else $error("negative leg outside differential mode");
    cal_end_a: assert property (calibration_start |=> !calibration_start && !calibration_busy)
        else $error("calibration start not one pulse");
endmodule

bind sfd_strap_decode sfd_chk u_chk (
    .core_clk, .sys_rst, .clk_pad(strap_cmp[5].above), .full_scale_range_select,
    .alternate_extended_control_enable, .ext_control_active, .differential_sync_mode,
    .calibration_delay_select, .dual_edge_sampling, .serial_chip_select_n, .output_clock_sync_neg,
    .sample_strobe, .calibration_start, .calibration_busy);

// file: testbench/sfd_strap_board.sv
`timescale 1ns/1ps
module sfd_strap_board (
    // Clock and settings from the bench.
    input wire logic                core_clk,
    input wire logic                run,
    input wire logic [3:0][1:0]     lvl,
    input wire logic                sync_pos,
    // Pad comparators toward the decoder.
    output sfd_pkg::sfd_cmp_s [5:0] strap_cmp
);
    logic [1:0] div_r;
    logic       clk_r;

    // The sample clock toggles every four core cycles and rests low when stopped.
    always_ff @(posedge core_clk) begin
        div_r <= run ? div_r + 2'h1 : 2'h0;
        if (!run) clk_r <= 1'b0;
        else if (div_r == 2'h3) clk_r <= !clk_r;
    end

    // A floating strap sits between both thresholds, so neither comparator trips.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            strap_cmp[i].above = (lvl[i] == sfd_pkg::SFD_LVL_HIGH);
            strap_cmp[i].below = (lvl[i] == sfd_pkg::SFD_LVL_LOW);
        end
        strap_cmp[4] = {sync_pos, !sync_pos};
        strap_cmp[5] = {clk_r, !clk_r};
    end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "sfd_consts.svh"
module testbench;
    localparam int SH = 4;
    localparam int LG = 16;
    // Strap codes per case, two bits per pad, and expected {ext,alt,diff,rng,des,long,cs_n}.
    localparam logic [47:0] PT = 48'h20_44_96_2a_65_24;
    localparam logic [41:0] ET = {7'b0011001, 7'b1000001, 7'b0001101, 7'b1100000, 7'b0001011, 7'b0000001};
    logic core_clk, sys_rst, run, sync_pos;
    logic [3:0][1:0] lv;
    sfd_pkg::sfd_cmp_s [5:0] strap_cmp;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic        rng, alt, ext, diff, cdly, des, cs_n, vld, neg, osync, strobe, cstart, cbusy;
    logic [6:0]  e;
    int          n_mismatch, n_tests, cyc, n;

    sfd_strap_board board (.core_clk, .run, .lvl(lv), .sync_pos, .strap_cmp);
    sfd_strap_decode #(.CAL_SHORT_CYC(SH), .CAL_LONG_CYC(LG)) DUT (
        .core_clk, .sys_rst, .strap_cmp,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .full_scale_range_select(rng), .alternate_extended_control_enable(alt),
        .ext_control_active(ext), .differential_sync_mode(diff), .calibration_delay_select(cdly),
        .dual_edge_sampling(des), .serial_chip_select_n(cs_n), .straps_valid(vld),
        .output_clock_sync_neg(neg), .output_clock_sync(osync), .sample_strobe(strobe),
        .calibration_start(cstart), .calibration_busy(cbusy));

    task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] g);
        n_tests++;
        if (g !== ex) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Each channel drops at the edge that takes it; only the ceiling ends a wait.
    task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
        {awaddr, wdata} <= {a, dv};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", er, bresp);
        bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [11:0] a);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {r, d} = {rresp, rdata};
        rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // Strobes while busy; the first may fall before busy is seen.
    task automatic cal_chk(input int k);
        n = 0;
        do begin
            @(posedge core_clk);
            if (strobe && cbusy) n++;
        end while (!cstart);
        chk("cal strobes", 1, (n >= k - 2 && n <= k + 1));
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Ceiling well above the run's length.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        {sys_rst, run, sync_pos, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
        {awaddr, araddr, wdata} = '0;
        lv = PT[7:0];
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        cal_chk(SH);
        rd(`SFD_REG_CTRL);
        chk("ctrl reset", 32'h1, d);
        rd(12'h010);
        chk("unmapped resp and data", {2'b10, 32'h0}, {r, d});
        wr(`SFD_REG_STATUS, 32'hff, `SFD_RESP_OKAY);
        wr(12'h010, 32'h2, `SFD_RESP_SLVERR);
        wr(`SFD_REG_CTRL, 32'h0, `SFD_RESP_OKAY);
        n = 0;
        repeat (80) begin
            @(posedge core_clk);
            if (strobe) n++;
        end
        chk("strobes per 80 cycles", 10, n);
        // Walk the strap cases: modes, status and pin codes.
        for (int i = 0; i < 6; i++) begin
            lv <= PT[8*i+:8];
            e = ET[7*i+:7];
            repeat (30) @(posedge core_clk);
            chk("modes", {1'b1, e}, {vld, ext, alt, diff, rng, des, cdly, cs_n});
            rd(`SFD_REG_STATUS);
            chk("status", {1'b1, e[1], e[2], e[3], e[4], e[5], e[6]}, {d[7], d[5:0]});
            rd(`SFD_REG_PINS);
            chk("pins", PT[8*i+:8], d[7:0]);
        end
        sync_pos <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk("sync legs low neg", 3'b101, {osync, neg, rng});
        lv[0] <= sfd_pkg::SFD_LVL_HIGH;
        repeat (30) @(posedge core_clk);
        chk("sync legs high neg", 3'b011, {osync, neg, rng});
        lv <= PT[15:8];
        repeat (30) @(posedge core_clk);
        lv[3] <= sfd_pkg::SFD_LVL_LOW;
        repeat (10) @(posedge core_clk);
        lv[3] <= sfd_pkg::SFD_LVL_HIGH;
        repeat (30) @(posedge core_clk);
        chk("glitch and single-ended sync", 3'b110, {cdly, osync, neg});
        wr(`SFD_REG_CTRL, 32'h2, `SFD_RESP_OKAY);
        cal_chk(LG);
        end_sim();
    end
endmodule
